// File: src/acs_defines.svh
// Register indices, field positions, reset values and link constants of the sequencer
// How it works
// - mode read returns alarm, error, selector
// - selector 00 manual 01 inline 10 auto 11 custom
// - input selector bits 2:0, reset zero
// - input selector bits 7:3 read zero
// - input selector write aborts running sequence, forces manual
// - start bit one starts auto/custom scan
// - start ignored in manual or inline mode
// - start bit zero does nothing
// - abort bit one stops auto/custom scan
// - abort ignored in manual or inline mode
// - inline enabled: first five input bits pick channel
// - inline enable resets zero, disables inline
// - inline selection needs no register write
// - inline register bits 7:1 read zero
// - mask bit n includes input n, reset zero
// - alarm mirrors pin, error flags bad configuration
// - auto scan ends once, or loops when repeating
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// Register indices; the byte address is four times the index
`define ACS_IDX_MODE      10'h01c
`define ACS_IDX_CHAN      10'h01d
`define ACS_IDX_START     10'h01e
`define ACS_IDX_ABORT     10'h01f
`define ACS_IDX_INLINE    10'h02a
`define ACS_IDX_MASK      10'h080
`define ACS_IDX_REPEAT    10'h082
`define ACS_IDX_IRQ_STS   10'h0c0
`define ACS_IDX_IRQ_MASK  10'h0c1
// Field positions
`define ACS_MODE_ALARM_BIT 3
`define ACS_MODE_ERR_BIT   2
`define ACS_TRIG_BIT       0
`define ACS_EV_DONE        0
`define ACS_EV_ABORT       1
`define ACS_EV_INLINE      2
// Reset values
`define ACS_MODE_RST       2'h0
`define ACS_CHAN_RST       3'h0
`define ACS_MASK_RST       8'h00
// Inline frame length in bits
`define ACS_INLINE_BITS    3'h5
`endif

// File: src/acs_pkg.sv
// Types shared by the channel sequencer register bank
package acs_pkg;
  typedef enum logic [1:0] {
    acs_mode_manual = 2'b00,
    acs_mode_inline = 2'b01,
    acs_mode_auto   = 2'b10,
    acs_mode_custom = 2'b11
  } acs_mode_t;
  typedef enum logic [1:0] {
    acs_idle = 2'b01,
    acs_run  = 2'b10
  } acs_scan_t;
endpackage

// File: src/acs_regs.sv
// Channel sequencer register bank with APB slave, link sampler and scan engine
`include "acs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_regs (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link pins, asynchronous to pclk
  input  wire logic        link_sclk,
  input  wire logic        link_sdi,
  input  wire logic        link_cs_n,
  // Alarm pin level
  input  wire logic        alarm_pin,
  // Multiplexer control and interrupt
  output logic      [2:0]  active_channel,
  output logic             scan_running,
  output logic             irq
);

  // Lowest enabled channel
  function automatic logic [3:0] acs_first_en(input logic [7:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  // Lowest enabled channel above cur
  function automatic logic [3:0] acs_next_en(input logic [7:0] m, input logic [2:0] cur);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && (3'(i) > cur)) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  acs_pkg::acs_mode_t mode;
  acs_pkg::acs_scan_t state;
  logic [7:0] scan_mask;
  logic       scan_repeat;
  logic       inline_en;
  logic [2:0] irq_sts;
  logic [2:0] irq_mask;
  logic [2:0] sclk_q;
  logic [1:0] sdi_q;
  logic [2:0] cs_q;
  logic [2:0] bit_cnt;
  logic [4:0] inline_code;
  logic [1:0] alarm_q;

  // Bus decode
  wire [9:0] idx      = paddr[11:2];
  wire sel_mode       = (idx == `ACS_IDX_MODE);
  wire sel_chan       = (idx == `ACS_IDX_CHAN);
  wire sel_start      = (idx == `ACS_IDX_START);
  wire sel_abort      = (idx == `ACS_IDX_ABORT);
  wire sel_inline     = (idx == `ACS_IDX_INLINE);
  wire sel_mask       = (idx == `ACS_IDX_MASK);
  wire sel_repeat     = (idx == `ACS_IDX_REPEAT);
  wire sel_ists       = (idx == `ACS_IDX_IRQ_STS);
  wire sel_imask      = (idx == `ACS_IDX_IRQ_MASK);
  wire mapped         = sel_mode | sel_chan | sel_start | sel_abort | sel_inline |
                        sel_mask | sel_repeat | sel_ists | sel_imask;
  wire access_wait    = psel & penable & ~pready;
  wire bus_wr         = psel & penable & pready & pwrite;
  wire wr_mode        = bus_wr & sel_mode;
  wire wr_chan        = bus_wr & sel_chan;
  wire wr_start       = bus_wr & sel_start;
  wire wr_abort       = bus_wr & sel_abort;

  // Status flags
  wire alarm_level    = alarm_q[1];
  wire running        = (state == acs_pkg::acs_run);
  wire seq_mode       = mode[1];
  wire cfg_error      = ((mode == acs_pkg::acs_mode_auto) && (scan_mask == 8'h00)) ||
                        ((mode == acs_pkg::acs_mode_inline) && !inline_en);

  // Read mux; reserved bits and trigger registers read zero
  wire [31:0] rd_data =
      sel_mode   ? {28'h0, alarm_level, cfg_error, mode} :
      sel_chan   ? {29'h0, active_channel} :
      sel_inline ? {31'h0, inline_en} :
      sel_mask   ? {24'h0, scan_mask} :
      sel_repeat ? {31'h0, scan_repeat} :
      sel_ists   ? {29'h0, irq_sts} :
      sel_imask  ? {29'h0, irq_mask} :
      32'h0;

  // Link sampling: pins pass two flops before any edge detection
  // The third flop only remembers the last level for the edge detect
  wire sclk_rise      = sclk_q[1] & ~sclk_q[2];
  wire frame_on       = ~cs_q[1];
  wire frame_end      = cs_q[1] & ~cs_q[2];
  wire inline_take    = frame_end & inline_en & (bit_cnt == `ACS_INLINE_BITS) &
                        ~running;

  // Scan engine controls
  // Stops beat a start in the same cycle, so an abort is never lost
  // Leaving a sequencing mode by a selector write counts as an abort
  wire start_go       = wr_start & pwdata[`ACS_TRIG_BIT] & seq_mode;
  wire abort_go       = wr_abort & pwdata[`ACS_TRIG_BIT] & seq_mode;
  wire chan_kill      = wr_chan & running;
  wire mode_kill      = wr_mode & running & ~pwdata[1];
  wire step           = frame_end & running & (mode == acs_pkg::acs_mode_auto);
  wire [3:0] first_ch = acs_first_en(scan_mask);
  wire [3:0] next_ch  = acs_next_en(scan_mask, active_channel);
  wire scan_end       = step & ~next_ch[3] & (~scan_repeat | ~first_ch[3]);
  wire stop_any       = chan_kill | mode_kill | (abort_go & running);
  wire [2:0] events   = {inline_take, stop_any, scan_end & ~stop_any & ~start_go};

  acs_pkg::acs_scan_t next_state;
  assign next_state = stop_any ? acs_pkg::acs_idle :
                      start_go ? acs_pkg::acs_run :
                      scan_end ? acs_pkg::acs_idle : state;

  logic [2:0] next_channel;
  assign next_channel =
      wr_chan                              ? pwdata[2:0] :
      (start_go & ~mode[0] & first_ch[3])  ? first_ch[2:0] :
      (step & next_ch[3])                  ? next_ch[2:0] :
      (step & scan_repeat & first_ch[3])   ? first_ch[2:0] :
      inline_take                          ? inline_code[2:0] : active_channel;

  wire [2:0] next_irq_sts = (irq_sts & ~(bus_wr & sel_ists ? pwdata[2:0] : 3'h0)) | events;

  // APB answer: one wait cycle, data and error registered with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access_wait;
      prdata  <= (access_wait & ~pwrite) ? rd_data : 32'h0;
      pslverr <= access_wait & ~mapped;
    end
  end

  // Configuration registers; channel write in a running scan forces manual
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode        <= acs_pkg::acs_mode_t'(`ACS_MODE_RST);
      scan_mask   <= `ACS_MASK_RST;
      scan_repeat <= 1'b0;
      inline_en   <= 1'b0;
      irq_mask    <= 3'h0;
    end else begin
      if (chan_kill) mode <= acs_pkg::acs_mode_manual;
      else if (wr_mode) mode <= acs_pkg::acs_mode_t'(pwdata[1:0]);
      if (bus_wr & sel_mask) scan_mask <= pwdata[7:0];
      if (bus_wr & sel_repeat) scan_repeat <= pwdata[0];
      if (bus_wr & sel_inline) inline_en <= pwdata[0];
      if (bus_wr & sel_imask) irq_mask <= pwdata[2:0];
    end
  end

  // Scan state, channel and interrupt; a new event beats a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= acs_pkg::acs_idle;
      scan_running   <= 1'b0;
      active_channel <= `ACS_CHAN_RST;
      irq_sts        <= 3'h0;
      irq            <= 1'b0;
    end else begin
      state          <= next_state;
      scan_running   <= (next_state == acs_pkg::acs_run);
      active_channel <= next_channel;
      irq_sts        <= next_irq_sts;
      irq            <= |(next_irq_sts & irq_mask);
    end
  end

  // Synchronisers for the asynchronous pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q  <= 3'h0;
      sdi_q   <= 2'h0;
      cs_q    <= 3'h7;
      alarm_q <= 2'h0;
    end else begin
      sclk_q  <= {sclk_q[1:0], link_sclk};
      sdi_q   <= {sdi_q[0], link_sdi};
      cs_q    <= {cs_q[1:0], link_cs_n};
      alarm_q <= {alarm_q[0], alarm_pin};
    end
  end

  // First five data bits of each frame, first bit most significant
  // Count saturates at five: long frames keep the first code
  // Limitation: sclk phases shorter than one pclk cycle can be missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt     <= 3'h0;
      inline_code <= 5'h00;
    end else if (!frame_on) begin
      bit_cnt <= 3'h0;
    end else if (sclk_rise && bit_cnt != `ACS_INLINE_BITS) begin
      bit_cnt     <= bit_cnt + 3'h1;
      inline_code <= {inline_code[3:0], sdi_q[1]};
    end
  end

  // Checks; all sampled on pclk and quiet while reset is low
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Transfer completions as the master sees them
  wire rd_done   = psel & penable & pready & ~pwrite;
  wire xfer_done = psel & penable & pready;
  wire mask_wr   = bus_wr & sel_mask;

  // Read-back of the mode word and of reserved bits
  mode_read_value_a: assert property (
      rd_done && sel_mode |->
      prdata[3:0] == {$past(alarm_level), $past(cfg_error), $past(mode)})
    else $error("mode read value wrong");
  chan_rsvd_zero_a: assert property (
      rd_done && sel_chan |-> prdata[31:3] == 29'h0)
    else $error("channel reserved bits not zero");
  inline_rsvd_a: assert property (
      rd_done && sel_inline |-> prdata[31:1] == 31'h0)
    else $error("inline reserved bits not zero");
  trig_read_zero_a: assert property (
      rd_done && (sel_start || sel_abort) |-> prdata == 32'h0)
    else $error("trigger register read not zero");

  // Selector and channel writes
  mode_write_take_a: assert property (
      wr_mode |=> mode == $past(pwdata[1:0]))
    else $error("selector write not applied");
  chan_write_take_a: assert property (
      wr_chan |=> active_channel == $past(pwdata[2:0]))
    else $error("channel write not applied");
  chan_write_abort_a: assert property (
      wr_chan && running |=> !scan_running && mode == acs_pkg::acs_mode_manual)
    else $error("channel write did not abort scan");
  custom_hold_a: assert property (
      running && mode == acs_pkg::acs_mode_custom && !wr_chan && !start_go
      |=> active_channel == $past(active_channel))
    else $error("custom run moved the channel");

  // Start and abort triggers
  start_scan_a: assert property (
      wr_start && pwdata[0] && mode[1] && !wr_mode |=> scan_running)
    else $error("start did not launch scan");
  start_ignored_a: assert property (
      wr_start && !mode[1] && !running |=> !scan_running)
    else $error("start acted in manual or inline mode");
  start_chan_keep_a: assert property (
      wr_start && !mode[1] && !inline_take |=> active_channel == $past(active_channel))
    else $error("start moved the channel in manual or inline mode");
  start_zero_a: assert property (
      wr_start && !pwdata[0] && running && !frame_end |=> scan_running)
    else $error("start zero stopped scan");
  start_zero_idle_a: assert property (
      wr_start && !pwdata[0] && !running |=> !scan_running)
    else $error("start zero launched scan");
  abort_stop_a: assert property (
      wr_abort && pwdata[0] && mode[1] |=> !scan_running)
    else $error("abort did not stop scan");
  abort_zero_a: assert property (
      wr_abort && !pwdata[0] && running && !frame_end |=> scan_running)
    else $error("abort zero stopped scan");
  abort_flag_a: assert property (
      abort_go && running |=> irq_sts[`ACS_EV_ABORT])
    else $error("abort event not flagged");
  abort_ignored_a: assert property (
      wr_abort && !mode[1] && running && !frame_end && !wr_mode |=> scan_running)
    else $error("abort acted in manual or inline mode");

  // Inline selection through the link
  inline_pick_a: assert property (
      inline_take && !wr_chan && !start_go |=>
      active_channel == $past(inline_code[2:0]))
    else $error("inline channel not taken");
  inline_off_a: assert property (
      !inline_en |-> !inline_take)
    else $error("inline selection while disabled");
  inline_flag_a: assert property (
      inline_take |=> irq_sts[`ACS_EV_INLINE])
    else $error("inline take not flagged");

  // Alarm mirror: two synchroniser flops of lag
  alarm_mirror_a: assert property (
      alarm_pin [*3] |=> alarm_level)
    else $error("alarm bit does not follow pin");
  alarm_clear_a: assert property (
      (!alarm_pin) [*3] |=> !alarm_level)
    else $error("alarm bit stuck high");

  // Scan engine: ordered walk over the mask, end or wrap
  auto_load_en_a: assert property (
      start_go && mode == acs_pkg::acs_mode_auto && first_ch[3] |=>
      scan_mask[active_channel])
    else $error("scan loaded a masked channel");
  auto_step_en_a: assert property (
      step && next_ch[3] && !stop_any && !start_go && !mask_wr |=>
      scan_mask[active_channel] && active_channel > $past(active_channel))
    else $error("scan stepped to a masked or lower channel");
  mask_write_take_a: assert property (
      mask_wr |=> scan_mask == $past(pwdata[7:0]))
    else $error("mask write not applied");
  scan_finish_a: assert property (
      step && !next_ch[3] && !scan_repeat && !stop_any && !start_go
      |=> !scan_running && irq_sts[`ACS_EV_DONE])
    else $error("scan did not end after last channel");
  repeat_wrap_a: assert property (
      step && !next_ch[3] && scan_repeat && first_ch[3] && !stop_any
      |=> scan_running && active_channel == $past(first_ch[2:0]))
    else $error("repeating scan did not wrap");

  // Bus answer and interrupt line
  pready_pulse_a: assert property (
      pready |=> !pready)
    else $error("ready held over two cycles");
  slverr_map_a: assert property (
      xfer_done |-> pslverr == !mapped)
    else $error("error response does not match decode");
  irq_level_a: assert property (
      1'b1 |=> irq == |(irq_sts & $past(irq_mask)))
    else $error("interrupt line disagrees with status");

  // Main scenarios
  start_auto_c: cover property (start_go && mode == acs_pkg::acs_mode_auto ##[1:200] scan_end);
  custom_run_c: cover property (start_go && mode == acs_pkg::acs_mode_custom);
  repeat_wrap_c: cover property (step && !next_ch[3] && scan_repeat && first_ch[3]);
  inline_c: cover property (inline_take);
  abort_c: cover property (abort_go && running);

endmodule
`default_nettype wire

// File: dv/acs_link_host.sv
// Serial link host model that sends inline channel frames
`timescale 1ns/1ps
`default_nettype none
module acs_link_host (
  // Link pins toward the sequencer
  output logic link_sclk,
  output logic link_sdi,
  output logic link_cs_n
);
  initial begin
    link_sclk = 1'b0;
    link_sdi  = 1'b1;
    link_cs_n = 1'b1;
  end
  // Code sent first bit high; clock stands still outside frames
  task automatic frame(input logic [4:0] code, input int nbits);
    link_cs_n = 1'b0;
    for (int i = 4; i > 4 - nbits; i--) begin
      link_sdi = code[i];
      #100 link_sclk = 1'b1;
      #100 link_sclk = 1'b0;
    end
    #100 link_cs_n = 1'b1;
    // Released line must not keep a stale bit
    link_sdi = ~link_sdi;
  endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench of the channel sequencer register bank
`include "acs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        alarm_pin, scan_running, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  active_channel;
  logic [7:0]  seed;
  wire logic   sclk, sdi, csn;
  int          fails, samples_checked, cyc;

  acs_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_sclk(sclk), .link_sdi(sdi), .link_cs_n(csn),
    .alarm_pin(alarm_pin), .active_channel(active_channel), .scan_running(scan_running),
    .irq(irq));
  acs_link_host link (.link_sclk(sclk), .link_sdi(sdi), .link_cs_n(csn));

  always #12.5 pclk = ~pclk;
  // Hang guard, well above the fewer than one thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      conclude();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Error flag: auto with empty mask, or inline without enable
  function automatic logic [31:0] mode_exp(input logic al, input logic [1:0] sel,
                                           input logic [7:0] m, input logic ie);
    return {28'h0, al, (sel == 2'b10 && m == 8'h00) || (sel == 2'b01 && !ie), sel};
  endfunction

  // APB transfer; waits on pready, settles two edges so effects are visible
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; alarm_pin = 0; seed = 8'h22;
    fails = 0; samples_checked = 0; cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("mode", `ACS_IDX_MODE, 32'h0);
    rchk("chan", `ACS_IDX_CHAN, 32'h0);
    rchk("start", `ACS_IDX_START, 32'h0);
    rchk("abort", `ACS_IDX_ABORT, 32'h0);
    rchk("inline", `ACS_IDX_INLINE, 32'h0);
    rchk("mask", `ACS_IDX_MASK, 32'h0);
    $display("test reset done");
    // Random input selector and mask values, input selector reserved bits set on purpose
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      apb(1'b1, `ACS_IDX_CHAN, {24'hffffff, seed});
      rchk("chan", `ACS_IDX_CHAN, {29'h0, seed[2:0]});
      chk("active_channel", {29'h0, seed[2:0]}, {29'h0, active_channel});
      apb(1'b1, `ACS_IDX_MASK, {24'h0, seed});
      rchk("mask", `ACS_IDX_MASK, {24'h0, seed});
    end
    apb(1'b1, `ACS_IDX_INLINE, 32'hff);
    rchk("inline", `ACS_IDX_INLINE, 32'h1);
    apb(1'b1, `ACS_IDX_START, 32'h1);
    rchk("start", `ACS_IDX_START, 32'h0);
    chk("running", 32'h0, {31'h0, scan_running});
    $display("test fields done");
    // All selector, alarm and error combinations
    for (int k = 0; k < 16; k++) begin
      alarm_pin <= k[2];
      apb(1'b1, `ACS_IDX_MASK, k[3] ? 32'h81 : 32'h0);
      apb(1'b1, `ACS_IDX_INLINE, {31'h0, k[3]});
      apb(1'b1, `ACS_IDX_MODE, {30'h0, k[1:0]});
      rchk("mode", `ACS_IDX_MODE,
           mode_exp(k[2], k[1:0], k[3] ? 8'h81 : 8'h0, k[3]));
    end
    alarm_pin <= 1'b0;
    $display("test mode done");
    // Auto scan over inputs 2 and 5, single pass
    apb(1'b1, `ACS_IDX_MASK, 32'h24);
    apb(1'b1, `ACS_IDX_IRQ_MASK, 32'h0);
    apb(1'b1, `ACS_IDX_MODE, 32'h2);
    apb(1'b1, `ACS_IDX_START, 32'h1);
    chk("running", 32'h1, {31'h0, scan_running});
    chk("active_channel", 32'h2, {29'h0, active_channel});
    apb(1'b1, `ACS_IDX_START, 32'h0);
    chk("running", 32'h1, {31'h0, scan_running});
    link.frame(5'h00, 5);
    repeat (8) @(posedge pclk);
    chk("active_channel", 32'h5, {29'h0, active_channel});
    link.frame(5'h00, 5);
    repeat (8) @(posedge pclk);
    chk("running", 32'h0, {31'h0, scan_running});
    rchk("irq_sts", `ACS_IDX_IRQ_STS, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `ACS_IDX_IRQ_MASK, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `ACS_IDX_IRQ_STS, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test auto done");
    // Custom run: abort bit zero ignored, one stops; input selector write aborts
    apb(1'b1, `ACS_IDX_MODE, 32'h3);
    apb(1'b1, `ACS_IDX_START, 32'h1);
    apb(1'b1, `ACS_IDX_ABORT, 32'h0);
    chk("running", 32'h1, {31'h0, scan_running});
    apb(1'b1, `ACS_IDX_ABORT, 32'h1);
    chk("running", 32'h0, {31'h0, scan_running});
    apb(1'b1, `ACS_IDX_START, 32'h1);
    apb(1'b1, `ACS_IDX_CHAN, 32'h6);
    chk("running", 32'h0, {31'h0, scan_running});
    rchk("mode", `ACS_IDX_MODE, 32'h0);
    $display("test abort done");
    // Inline selection through the link, then disabled and short frames
    apb(1'b1, `ACS_IDX_MODE, 32'h1);
    apb(1'b1, `ACS_IDX_START, 32'h1);
    chk("running", 32'h0, {31'h0, scan_running});
    seed = lfsr(seed);
    link.frame(seed[4:0], 5);
    repeat (8) @(posedge pclk);
    chk("active_channel", {29'h0, seed[2:0]}, {29'h0, active_channel});
    link.frame(~seed[4:0], 3);
    repeat (8) @(posedge pclk);
    chk("active_channel", {29'h0, seed[2:0]}, {29'h0, active_channel});
    apb(1'b1, `ACS_IDX_INLINE, 32'h0);
    link.frame(~seed[4:0], 5);
    repeat (8) @(posedge pclk);
    chk("active_channel", {29'h0, seed[2:0]}, {29'h0, active_channel});
    apb(1'b0, 10'h3ff, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    $display("test inline done");
    conclude();
  end
endmodule
`default_nettype wire
